// ==== rtl/tcc_timer_ctrl.sv ====
// Timer/counter 0, 1 and 2 control core with an AXI4-Lite register slave.
// Assumes external pins are asynchronous and the CPU acknowledge lines run on aclk.
`timescale 1ns/10ps
`include "tcc_regs.svh"
module tcc_timer_ctrl (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pins: count inputs for timers 0..2, external irq 0..1
    input wire logic [2:0] count_pin,
    input wire logic [1:0] external_irq_pin,
    input wire logic t2_dir_pin,
    input wire logic clocking_mode_option,
    output logic t2_clock_out,
    // CPU vectoring: {timer1, ext1, timer0, ext0}
    input wire logic [3:0] irq_ack,
    output logic [3:0] irq_req
);
    tcc_pin_if pins ();
    logic aw_held, w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_fire;
    logic [32:0] rd_word;
    logic [32:0] wr_word;
    logic [7:0] timer01_mode, timer01_control, timer2_mode, timer2_ctrl;
    logic [7:0] tl0, th0, tl1, th1;
    logic [15:0] t2_cnt;
    logic [2:0] cnt_prev;
    logic [1:0] irq_prev;
    logic [2:0] pin_fall;
    logic [16:0] step0, step1;
    logic inc0, inc0h, inc1, inc2, ovf0, ovf0h, ovf1, ovf2, t0_split, t1_stop;
    logic [1:0] ext_set;
    tcc_pkg::tcc_mode_e mode0, mode1;

    tcc_pin_sync u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .count_pin(count_pin),
        .external_irq_pin(external_irq_pin),
        .t2_dir_pin(t2_dir_pin),
        .clocking_mode_option(clocking_mode_option),
        .pins(pins)
    );

    // One count step; returns {overflow, high, low}
    function automatic logic [16:0] tcc_step(input tcc_pkg::tcc_mode_e mode,
                                             input logic [15:0] cnt);
        logic [5:0] lo5;
        logic [8:0] hi9;
        logic [8:0] lo9;
        begin
            lo5 = {1'b0, cnt[4:0]} + 6'h01;
            hi9 = {1'b0, cnt[15:8]} + {8'h00, lo5[5]};
            lo9 = {1'b0, cnt[7:0]} + 9'h001;
            unique case (mode)
                tcc_pkg::TCC_MODE_13BIT: begin
                    tcc_step = {hi9, cnt[7:5], lo5[4:0]};
                end
                tcc_pkg::TCC_MODE_16BIT: begin
                    tcc_step = {1'b0, cnt} + 17'h00001;
                end
                tcc_pkg::TCC_MODE_RELOAD8: begin
                    tcc_step = {lo9[8], cnt[15:8], lo9[8] ? cnt[15:8] : lo9[7:0]};
                end
                tcc_pkg::TCC_MODE_SPLIT: begin
                    tcc_step = {lo9[8], cnt[15:8], lo9[7:0]};
                end
            endcase
        end
    endfunction : tcc_step

    // Register read decode; returns {error, data}
    function automatic logic [32:0] tcc_read(input logic [7:0] addr);
        begin
            tcc_read = {1'b0, 32'h00000000};
            unique case (addr)
                `TCC_OFF_MODE: tcc_read[7:0] = timer01_mode;
                `TCC_OFF_CTRL: tcc_read[7:0] = timer01_control;
                `TCC_OFF_T2MODE: tcc_read[1:0] = timer2_mode[1:0];
                `TCC_OFF_TL0: tcc_read[7:0] = tl0;
                `TCC_OFF_TH0: tcc_read[7:0] = th0;
                `TCC_OFF_TL1: tcc_read[7:0] = tl1;
                `TCC_OFF_TH1: tcc_read[7:0] = th1;
                `TCC_OFF_T2CTRL: tcc_read[7:0] = timer2_ctrl;
                `TCC_OFF_T2CNT: tcc_read[15:0] = t2_cnt;
                default: tcc_read[32] = 1'b1;
            endcase
        end
    endfunction : tcc_read

    // Decoded words for the read address and the held write address
    assign rd_word = tcc_read(s_axi_araddr);
    assign wr_word = tcc_read(aw_addr);

    // Write channel capture; address and data may arrive in either order
    assign s_axi_awready = !aw_held;
    assign s_axi_wready = !w_held;
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
        end else begin
            if (s_axi_awvalid && !aw_held) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && !w_held) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held <= 1'b0;
            end
        end
    end

    // Write response, one cycle after both halves are held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `TCC_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_word[32] ? `TCC_RESP_SLVERR : `TCC_RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read channel; data registered, unmapped reads return zero with an error
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `TCC_RESP_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word[31:0];
            s_axi_rresp <= rd_word[32] ? `TCC_RESP_SLVERR : `TCC_RESP_OKAY;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Pin samples taken once per machine cycle for the falling-edge counters
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_prev <= 3'h7;
        end else if (pins.tick) begin
            cnt_prev <= pins.count_s;
        end
    end
    assign pin_fall = {3{pins.tick}} & cnt_prev & ~pins.count_s;

    // Count enables for timers 0 and 1
    always_comb begin
        mode0 = tcc_pkg::tcc_mode_e'(timer01_mode[1:0]);
        mode1 = tcc_pkg::tcc_mode_e'(timer01_mode[5:4]);
        t0_split = (mode0 == tcc_pkg::TCC_MODE_SPLIT);
        t1_stop = (mode1 == tcc_pkg::TCC_MODE_SPLIT);
        inc0 = timer01_control[`TCC_TR0]
            && (!timer01_mode[`TCC_GATE] || pins.irq_s[0])
            && (timer01_mode[`TCC_CT] ? pin_fall[0] : pins.tick);
        inc1 = !t1_stop && timer01_control[`TCC_TR1]
            && (!timer01_mode[`TCC_GATE + 4] || pins.irq_s[1])
            && (timer01_mode[`TCC_CT + 4] ? pin_fall[1] : pins.tick);
        // High byte of split timer 0 is timer-only and borrows timer 1 run
        inc0h = t0_split && timer01_control[`TCC_TR1] && pins.tick;
        step0 = tcc_step(mode0, {th0, tl0});
        step1 = tcc_step(mode1, {th1, tl1});
        ovf0 = inc0 && step0[16];
        ovf1 = inc1 && step1[16];
        ovf0h = inc0h && (th0 == 8'hFF);
    end

    // Timer 0 and 1 counts; a bus write wins over a count in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tl0 <= `TCC_RST_BYTE;
            th0 <= `TCC_RST_BYTE;
            tl1 <= `TCC_RST_BYTE;
            th1 <= `TCC_RST_BYTE;
        end else begin
            if (wr_fire && aw_addr == `TCC_OFF_TL0 && w_strb[0]) tl0 <= w_data[7:0];
            else if (inc0) tl0 <= step0[7:0];
            if (wr_fire && aw_addr == `TCC_OFF_TH0 && w_strb[0]) th0 <= w_data[7:0];
            else if (inc0h) th0 <= th0 + 8'h01;
            else if (inc0 && !t0_split) th0 <= step0[15:8];
            if (wr_fire && aw_addr == `TCC_OFF_TL1 && w_strb[0]) tl1 <= w_data[7:0];
            else if (inc1) tl1 <= step1[7:0];
            if (wr_fire && aw_addr == `TCC_OFF_TH1 && w_strb[0]) th1 <= w_data[7:0];
            else if (inc1) th1 <= step1[15:8];
        end
    end

    // Mode registers and timer 2 control bits other than the flag
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer01_mode <= `TCC_RST_BYTE;
            timer2_mode <= `TCC_RST_BYTE;
            timer2_ctrl[6:0] <= 7'h00;
        end else if (wr_fire && w_strb[0]) begin
            if (aw_addr == `TCC_OFF_MODE) timer01_mode <= w_data[7:0];
            if (aw_addr == `TCC_OFF_T2MODE) timer2_mode <= {6'h00, w_data[1:0]};
            if (aw_addr == `TCC_OFF_T2CTRL) timer2_ctrl[6:0] <= w_data[6:0];
        end
    end

    // Trigger per external irq: falling edge or low level
    always_ff @(posedge aclk) begin
        if (!aresetn) irq_prev <= 2'h3;
        else irq_prev <= pins.irq_s;
    end
    assign ext_set[0] = timer01_control[`TCC_IT0] ? (irq_prev[0] && !pins.irq_s[0])
                                                  : !pins.irq_s[0];
    assign ext_set[1] = timer01_control[`TCC_IT1] ? (irq_prev[1] && !pins.irq_s[1])
                                                  : !pins.irq_s[1];

    // Control register; hardware set wins over vectoring or software clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer01_control <= `TCC_RST_BYTE;
        end else begin
            if (wr_fire && aw_addr == `TCC_OFF_CTRL && w_strb[0]) begin
                timer01_control[`TCC_TR1] <= w_data[`TCC_TR1];
                timer01_control[`TCC_TR0] <= w_data[`TCC_TR0];
                timer01_control[`TCC_IT1] <= w_data[`TCC_IT1];
                timer01_control[`TCC_IT0] <= w_data[`TCC_IT0];
                timer01_control[`TCC_TF1] <= w_data[`TCC_TF1] || (t0_split ? ovf0h : ovf1);
                timer01_control[`TCC_TF0] <= w_data[`TCC_TF0] || ovf0;
                timer01_control[`TCC_IE1] <= w_data[`TCC_IE1] || ext_set[1];
                timer01_control[`TCC_IE0] <= w_data[`TCC_IE0] || ext_set[0];
            end else begin
                timer01_control[`TCC_TF1] <= (t0_split ? ovf0h : ovf1)
                    || (timer01_control[`TCC_TF1] && !irq_ack[3]);
                timer01_control[`TCC_TF0] <= ovf0
                    || (timer01_control[`TCC_TF0] && !irq_ack[1]);
                timer01_control[`TCC_IE1] <= ext_set[1]
                    || (timer01_control[`TCC_IE1] && !irq_ack[2]);
                timer01_control[`TCC_IE0] <= ext_set[0]
                    || (timer01_control[`TCC_IE0] && !irq_ack[0]);
            end
        end
    end
    assign irq_req = {timer01_control[`TCC_TF1], timer01_control[`TCC_IE1],
                      timer01_control[`TCC_TF0], timer01_control[`TCC_IE0]};

    // Timer 2: up, or down when enabled and the direction pin is low
    assign inc2 = timer2_ctrl[`TCC_T2RUN]
        && (timer2_ctrl[`TCC_T2CT] ? pin_fall[2] : pins.tick);
    assign ovf2 = inc2 && ((timer2_mode[`TCC_TIMER2_DOWNCOUNT_ENABLE] && !pins.dir_s) ? (t2_cnt == 16'h0000)
                                                                   : (t2_cnt == 16'hFFFF));
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            t2_cnt <= `TCC_RST_WORD;
        end else if (wr_fire && aw_addr == `TCC_OFF_T2CNT && w_strb[1:0] != 2'h0) begin
            if (w_strb[0]) t2_cnt[7:0] <= w_data[7:0];
            if (w_strb[1]) t2_cnt[15:8] <= w_data[15:8];
        end else if (inc2) begin
            if (timer2_mode[`TCC_TIMER2_DOWNCOUNT_ENABLE] && !pins.dir_s) t2_cnt <= t2_cnt - 16'h0001;
            else t2_cnt <= t2_cnt + 16'h0001;
        end
    end

    // Timer 2 flag, suppressed while the clock output is in use
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer2_ctrl[`TCC_T2TF] <= 1'b0;
        end else begin
            timer2_ctrl[`TCC_T2TF] <= (ovf2 && !timer2_mode[`TCC_TIMER2_CLOCK_OUT_ENABLE])
                || ((wr_fire && aw_addr == `TCC_OFF_T2CTRL && w_strb[0])
                    ? w_data[`TCC_T2TF] : timer2_ctrl[`TCC_T2TF]);
        end
    end

    // Clock output toggles on each overflow in timer mode, so its period is two overflows
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            t2_clock_out <= 1'b0;
        end else if (ovf2 && timer2_mode[`TCC_TIMER2_CLOCK_OUT_ENABLE] && !timer2_ctrl[`TCC_T2CT]) begin
            t2_clock_out <= !t2_clock_out;
        end
    end

    // Checks
    property p_tick_space;
        @(posedge aclk) disable iff (!aresetn) pins.tick |=> !pins.tick [*5];
    endproperty
    a_tick_space: assert property (p_tick_space) else $error("machine cycle too short");
    property p_run_off;
        @(posedge aclk) disable iff (!aresetn)
            !timer01_control[`TCC_TR0] && !wr_fire |=> $stable(tl0);
    endproperty
    a_run_off: assert property (p_run_off) else $error("timer 0 counted while stopped");
    property p_gate;
        @(posedge aclk) disable iff (!aresetn)
            timer01_mode[`TCC_GATE] && !pins.irq_s[0] && !wr_fire |=> $stable(tl0);
    endproperty
    a_gate: assert property (p_gate) else $error("gated timer 0 counted");
    property p_reload;
        @(posedge aclk) disable iff (!aresetn)
            mode0 == tcc_pkg::TCC_MODE_RELOAD8 && inc0 && tl0 == 8'hFF && !wr_fire
            |=> tl0 == $past(th0) && th0 == $past(th0) && timer01_control[`TCC_TF0];
    endproperty
    a_reload: assert property (p_reload) else $error("reload mode overflow wrong");
    property p_m13;
        @(posedge aclk) disable iff (!aresetn)
            mode0 == tcc_pkg::TCC_MODE_13BIT && inc0 && tl0[4:0] == 5'h1F && !wr_fire
            |=> tl0[4:0] == 5'h00 && th0 == $past(th0) + 8'h01;
    endproperty
    a_m13: assert property (p_m13) else $error("13-bit carry wrong");
    property p_m16;
        @(posedge aclk) disable iff (!aresetn)
            mode0 == tcc_pkg::TCC_MODE_16BIT && inc0 && {th0, tl0} == 16'hFFFF && !wr_fire
            |=> {th0, tl0} == 16'h0000 && timer01_control[`TCC_TF0];
    endproperty
    a_m16: assert property (p_m16) else $error("16-bit overflow wrong");
    property p_t1_stop;
        @(posedge aclk) disable iff (!aresetn) t1_stop && !wr_fire |=> $stable({th1, tl1});
    endproperty
    a_t1_stop: assert property (p_t1_stop) else $error("timer 1 ran in mode 3");
    property p_edge;
        @(posedge aclk) disable iff (!aresetn)
            timer01_control[`TCC_IT0] && $fell(pins.irq_s[0]) |=> timer01_control[`TCC_IE0];
    endproperty
    a_edge: assert property (p_edge) else $error("edge flag not set");
    property p_clkout;
        @(posedge aclk) disable iff (!aresetn)
            ovf2 && timer2_mode[`TCC_TIMER2_CLOCK_OUT_ENABLE] && !timer2_ctrl[`TCC_T2CT]
            |=> t2_clock_out != $past(t2_clock_out);
    endproperty
    a_clkout: assert property (p_clkout) else $error("clock output missed toggle");
    c_reload: cover property (@(posedge aclk) disable iff (!aresetn)
        mode0 == tcc_pkg::TCC_MODE_RELOAD8 && ovf0);
    c_split: cover property (@(posedge aclk) disable iff (!aresetn) ovf0h);
    c_clkout: cover property (@(posedge aclk) disable iff (!aresetn) $rose(t2_clock_out));
    c_read: cover property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && s_axi_rready);
endmodule : tcc_timer_ctrl

// ==== rtl/tcc_regs.svh ====
// Register offsets, field positions, reset values and timing counts of the timer block.
// Assumes byte addresses on an 8-bit AXI4-Lite address, one 32-bit word per register.
`ifndef TCC_REGS_SVH
`define TCC_REGS_SVH
// Byte offsets
`define TCC_OFF_MODE 8'h00
`define TCC_OFF_CTRL 8'h04
`define TCC_OFF_T2MODE 8'h08
`define TCC_OFF_TL0 8'h0C
`define TCC_OFF_TH0 8'h10
`define TCC_OFF_TL1 8'h14
`define TCC_OFF_TH1 8'h18
`define TCC_OFF_T2CTRL 8'h1C
`define TCC_OFF_T2CNT 8'h20
// Control register fields
`define TCC_TF1 7
`define TCC_TR1 6
`define TCC_TF0 5
`define TCC_TR0 4
`define TCC_IE1 3
`define TCC_IT1 2
`define TCC_IE0 1
`define TCC_IT0 0
// Mode register fields, per nibble
`define TCC_GATE 3
`define TCC_CT 2
// Timer 2 fields
`define TCC_TIMER2_CLOCK_OUT_ENABLE 1
`define TCC_TIMER2_DOWNCOUNT_ENABLE 0
`define TCC_T2RUN 0
`define TCC_T2CT 1
`define TCC_T2TF 7
// Reset values
`define TCC_RST_BYTE 8'h00
`define TCC_RST_WORD 16'h0000
// Machine cycle lengths in oscillator periods, one period per aclk
`define TCC_PERIODS_12T 4'hC
`define TCC_PERIODS_6T 4'h6
// Bus responses
`define TCC_RESP_OKAY 2'h0
`define TCC_RESP_SLVERR 2'h2
`endif

// ==== rtl/tcc_pkg.sv ====
// Types shared by the timer block modules.
// Assumes tcc_regs.svh supplies the numeric constants.
package tcc_pkg;
    typedef enum logic [1:0] {
        TCC_MODE_13BIT,
        TCC_MODE_16BIT,
        TCC_MODE_RELOAD8,
        TCC_MODE_SPLIT
    } tcc_mode_e;
endpackage : tcc_pkg

// ==== rtl/tcc_pin_if.sv ====
// Synchronised pin levels and machine-cycle tick between the pin front end and the core.
// Assumes both ends run on aclk.
`timescale 1ns/10ps
interface tcc_pin_if;
    logic tick;
    logic mode12;
    logic [2:0] count_s;
    logic [1:0] irq_s;
    logic dir_s;
    modport front (output tick, output mode12, output count_s, output irq_s, output dir_s);
    modport core (input tick, input mode12, input count_s, input irq_s, input dir_s);
endinterface : tcc_pin_if

// ==== rtl/tcc_pin_sync.sv ====
// Pin synchronisers and machine-cycle prescaler.
// Assumes the oscillator period equals one aclk period.
`timescale 1ns/10ps
`include "tcc_regs.svh"
module tcc_pin_sync (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Raw pins
    input wire logic [2:0] count_pin,
    input wire logic [1:0] external_irq_pin,
    input wire logic t2_dir_pin,
    input wire logic clocking_mode_option,
    // Core side
    tcc_pin_if.front pins
);
    logic [6:0] sync_a;
    logic [6:0] sync_b;
    logic [3:0] presc;
    logic [3:0] limit;

    // Two flops per pin; only sync_b is used downstream
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_a <= 7'h7F;
            sync_b <= 7'h7F;
        end else begin
            sync_a <= {clocking_mode_option, t2_dir_pin, external_irq_pin, count_pin};
            sync_b <= sync_a;
        end
    end

    assign pins.count_s = sync_b[2:0];
    assign pins.irq_s = sync_b[4:3];
    assign pins.dir_s = sync_b[5];
    assign pins.mode12 = sync_b[6];
    // Option 1 gives twelve periods, 0 gives six
    assign limit = sync_b[6] ? `TCC_PERIODS_12T : `TCC_PERIODS_6T;

    // Machine-cycle prescaler; a mode change applies to the machine cycle in progress
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            presc <= 4'h0;
        end else if (presc >= limit - 4'h1) begin
            presc <= 4'h0;
        end else begin
            presc <= presc + 4'h1;
        end
    end

    assign pins.tick = (presc == limit - 4'h1);
endmodule : tcc_pin_sync

// ==== testbench/tcc_pin_model.sv ====
// Pin source for the timer block: count, irq and direction lines.
// Assumes the bench pulses req for one cycle per wanted falling edge.
`timescale 1ns/10ps
module tcc_pin_model (
    // Clock
    input wire logic aclk,
    // Requests: {irq1, irq0, count2, count1, count0}
    input wire logic [4:0] req,
    // Pins, idle high as if pulled up
    output logic [2:0] count_pin,
    output logic [1:0] external_irq_pin,
    output logic t2_dir_pin,
    output logic busy
);
    logic [5:0] cnt [5] = '{default: 6'h00};
    // Low 24 cycles then high 24, each over a 12-period machine cycle
    always @(posedge aclk) begin
        for (int i = 0; i < 5; i++) begin
            if (cnt[i] != 6'h00) cnt[i] <= cnt[i] - 6'h01;
            else if (req[i]) cnt[i] <= 6'h30;
        end
    end
    // Line levels from the counters
    always_comb begin
        for (int i = 0; i < 3; i++) count_pin[i] = !(cnt[i] > 6'h18);
        for (int i = 0; i < 2; i++) external_irq_pin[i] = !(cnt[i + 3] > 6'h18);
        busy = (cnt[0] | cnt[1] | cnt[2] | cnt[3] | cnt[4]) != 6'h00;
    end
    assign t2_dir_pin = 1'b1; // Up only, timer 2 is exercised counting up
endmodule : tcc_pin_model

// ==== testbench/timer_counter_control_tb.sv ====
// Self-checking bench for the timer control block over AXI4-Lite.
// Assumes tcc_pin_model drives the pins and the offsets in tcc_regs.svh.
`timescale 1ns/10ps
`include "tcc_regs.svh"
module timer_counter_control_tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic opt = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, t2_clock_out, busy, dir;
    logic [1:0] bresp, rresp, irq_pin;
    logic [2:0] cpin;
    logic [3:0] ack = 4'h0, irq_req;
    logic [4:0] req = 5'h00;
    int error_cnt = 0, checks = 0, cyc = 0, n;
    tcc_timer_ctrl tcc_timer_ctrl_inst (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .count_pin(cpin),
        .external_irq_pin(irq_pin), .t2_dir_pin(dir), .clocking_mode_option(opt),
        .t2_clock_out(t2_clock_out), .irq_ack(ack), .irq_req(irq_req));
    tcc_pin_model tcc_pin_model_inst (.aclk(aclk), .req(req), .count_pin(cpin),
        .external_irq_pin(irq_pin), .t2_dir_pin(dir), .busy(busy));
    // Free-running clock, 4 ns
    initial forever #2 aclk = ~aclk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Write: both halves offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ha, hw, hb;
        logic [1:0] rs;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            #1;
            ha = awvalid && awready;
            hw = wvalid && wready;
            hb = bvalid;
            rs = bresp;
            @(posedge aclk);
            if (ha) awvalid <= 1'b0;
            if (hw) wvalid <= 1'b0;
        end while (!hb);
        bready <= 1'b0;
        chk(32'(rs), 32'h0);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        logic ha, hr;
        logic [31:0] d;
        logic [1:0] rs;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            #1;
            ha = arvalid && arready;
            hr = rvalid;
            d = rdata;
            rs = rresp;
            @(posedge aclk);
            if (ha) arvalid <= 1'b0;
        end while (!hr);
        rready <= 1'b0;
        chk(d, e);
        chk(32'(rs), 32'(er));
    endtask : rd
    // Bounded wait for one request line; cycles waited come back in n
    task automatic wait_irq(input int i);
        n = 0;
        while (irq_req[i] !== 1'b1 && n < 300) begin
            @(posedge aclk);
            #1;
            n++;
        end
    endtask : wait_irq
    // Timer 2 counting up from near full; the clock output must toggle, flag stays clear
    task automatic t_t2;
        wr(`TCC_OFF_T2CNT, 32'hFFFE);
        wr(`TCC_OFF_T2CTRL, 32'h01);
        n = 0;
        while (t2_clock_out !== 1'b1 && n < 300) begin
            @(posedge aclk);
            #1;
            n++;
        end
        chk(32'(t2_clock_out), 32'h1);
        rd(`TCC_OFF_T2CTRL, 32'h01, 2'h0);
    endtask : t_t2
    task automatic pulse(input logic [4:0] r, input logic [3:0] a);
        @(posedge aclk);
        req <= r;
        ack <= a;
        @(posedge aclk);
        req <= 5'h00;
        ack <= 4'h0;
        #1;
        while (busy) @(posedge aclk);
        repeat (4) @(posedge aclk);
    endtask : pulse
    task automatic t_regs;
        rd(`TCC_OFF_CTRL, 32'h0, 2'h0);
        wr(`TCC_OFF_MODE, 32'hA5);
        rd(`TCC_OFF_MODE, 32'hA5, 2'h0);
        wr(`TCC_OFF_T2MODE, 32'h3);
        rd(`TCC_OFF_T2MODE, 32'h3, 2'h0);
        rd(8'h40, 32'h0, 2'h2);
    endtask : t_regs
    // 16 ticks of six periods to overflow, then flag clear by a register write
    task automatic t_ovf;
        wr(`TCC_OFF_MODE, 32'h01);
        wr(`TCC_OFF_TL0, 32'hF0);
        wr(`TCC_OFF_TH0, 32'hFF);
        wr(`TCC_OFF_CTRL, 32'h10);
        wait_irq(1);
        chk(32'(n >= 85 && n <= 100), 32'h1);
        rd(`TCC_OFF_CTRL, 32'h30, 2'h0);
        wr(`TCC_OFF_CTRL, 32'h00);
        rd(`TCC_OFF_CTRL, 32'h00, 2'h0);
    endtask : t_ovf
    // Eight ticks of twelve periods, then reload from a full high byte
    task automatic t_reload;
        opt <= 1'b1;
        wr(`TCC_OFF_MODE, 32'h20);
        wr(`TCC_OFF_TL1, 32'hF8);
        wr(`TCC_OFF_TH1, 32'hFF);
        wr(`TCC_OFF_CTRL, 32'h40);
        wait_irq(3);
        chk(32'(n >= 85 && n <= 100), 32'h1);
        wr(`TCC_OFF_CTRL, 32'h80);
        rd(`TCC_OFF_TL1, 32'hFF, 2'h0);
        rd(`TCC_OFF_TH1, 32'hFF, 2'h0);
        pulse(5'h00, 4'h8);
        chk(32'(irq_req[3]), 32'h0);
    endtask : t_reload
    task automatic t_count;
        wr(`TCC_OFF_MODE, 32'h05);
        wr(`TCC_OFF_TL0, 32'h00);
        wr(`TCC_OFF_CTRL, 32'h10);
        repeat (3) pulse(5'h01, 4'h0);
        rd(`TCC_OFF_TL0, 32'h03, 2'h0);
    endtask : t_count
    // Count edge while the gate pin is low must not count, but flags an edge
    task automatic t_gate;
        wr(`TCC_OFF_MODE, 32'h0D);
        wr(`TCC_OFF_TL0, 32'h00);
        wr(`TCC_OFF_CTRL, 32'h11);
        pulse(5'h09, 4'h0);
        rd(`TCC_OFF_TL0, 32'h00, 2'h0);
        chk(32'(irq_req[0]), 32'h1);
        pulse(5'h00, 4'h1);
        chk(32'(irq_req[0]), 32'h0);
    endtask : t_gate
    task automatic final_report;
        $display("checks=%0d error_cnt=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : final_report
    // Hang guard, far above the several hundred cycles needed
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            final_report();
        end
    end
    // Main sequence
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_ovf();
        t_reload();
        t_count();
        t_gate();
        t_t2();
        final_report();
    end
endmodule : timer_counter_control_tb
